/* rtl/pab_backend.sv */
// fifo and top of the pipelined converter digital back end
`timescale 1ns/1ps

// plain valid/ready buffer built from flops only
module pab_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, low
    // write side
    input wire logic inValid, // write request
    output logic inReady, // room for a word
    input wire logic [WIDTH-1:0] inData, // word written
    // read side
    output logic outValid, // head word present
    input wire logic outReady, // head taken
    output logic [WIDTH-1:0] outData // head word
);
    // pointer width; a depth of one would need special care
    localparam int AW = $clog2(DEPTH);

    // storage, both pointers and the occupancy in one record
    typedef struct packed {
        // word slots, indexed by the pointers
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        // next slot to fill
        logic [AW-1:0] wrPtr;
        // slot shown at the head
        logic [AW-1:0] rdPtr;
        // one bit wider so full and empty differ
        logic [AW:0] count;
    } pab_fifo_s;

    // current and next state
    pab_fifo_s st_q, st_d;
    // accepted write this cycle
    logic doWrite;
    // accepted read this cycle
    logic doRead;

    // honest flags straight from the occupancy count
    assign inReady = (st_q.count != (AW + 1)'(DEPTH));
    assign outValid = (st_q.count != '0);

    // head word read from its slot, no extra cycle of latency
    assign outData = st_q.mem[st_q.rdPtr];

    // a transfer happens only when both sides agree
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // pointers wrap by hand so depth need not be a power of two
    always_comb begin
        st_d = st_q;

        // write side
        if (doWrite) begin
            st_d.mem[st_q.wrPtr] = inData;
            st_d.wrPtr = (st_q.wrPtr == AW'(DEPTH - 1)) ? '0 : st_q.wrPtr + 1'b1;
        end

        // read side
        if (doRead) begin
            st_d.rdPtr = (st_q.rdPtr == AW'(DEPTH - 1)) ? '0 : st_q.rdPtr + 1'b1;
        end

        // simultaneous read and write leave the count alone
        if (doWrite && !doRead) begin
            st_d.count = st_q.count + 1'b1;
        end else if (doRead && !doWrite) begin
            st_d.count = st_q.count - 1'b1;
        end
    end

    // everything clears on reset, so the buffer starts empty
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// top: synchronisers, phase generator, delay lines, correction and buffer
module pab_backend #(
    parameter int NSTAGE = pab_pkg::NUM_STAGES,
    parameter int DEPTH = pab_pkg::FIFO_DEPTH
) (
    // clocking
    input wire logic clk, // system clock, 10 MHz
    input wire logic reset_n, // async reset, low
    // converter side pins
    input wire logic convClk, // convert clock pin
    input wire logic [NSTAGE*pab_pkg::CODE_BITS-1:0] stageCode, // quantizer codes, stage 0 low
    input wire logic outDisable_n, // output-disable pin, high floats bus
    input wire logic sleepReq, // sleep pin, high floats bus
    // switch phases
    output logic phase1, // sampling switch phase
    output logic phase2, // hold and redistribute phase
    // output bus
    output logic [pab_pkg::RES_BITS-1:0] resultData, // result word, bit 9 msb
    output logic [pab_pkg::RES_BITS-1:0] resultOe, // per-bit output enable
    // downstream stream
    output logic resultValid, // head word valid
    input wire logic resultReady, // downstream takes word
    output logic bufferReady // fifo has room
);
    import pab_pkg::*;

    // width of the whole code bus
    localparam int CW = NSTAGE * CODE_BITS;

    // every flop of the block lives in this one record
    typedef struct packed {
        // pin synchronisers, two flops each before any logic reads them
        logic [SYNC_STAGES-1:0] convSync;
        logic convPrev;
        logic [SYNC_STAGES-1:0] disSync;
        logic [SYNC_STAGES-1:0] sleepSync;
        logic [SYNC_STAGES-1:0][CW-1:0] codeSync;

        // switch phase generator
        pab_phase_e phase;

        // per-stage delay lines, tap zero is the newest code
        logic [NSTAGE-1:0][MAX_DELAY:0][CODE_BITS-1:0] dly;

        // corrected word waiting for the next convert edge
        logic [RES_BITS-1:0] word;
        logic wordValid;

        // words still to be thrown away after reset or sleep
        logic [2:0] invalidCnt;
    } pab_top_s;

    // current and next state
    pab_top_s st_q, st_d;

    // edges of the synchronised convert clock
    logic convRise;
    logic convFall;

    // qualified pin levels
    logic sleeping;
    logic drive;

    // datapath
    logic pushValid;
    logic [CW-1:0] codes;
    logic [RES_BITS-1:0] corrected;

    // delay in convert cycles for a stage; later stages settle later
    // two stages share each delay depth except the last stage, which has depth zero alone; stage zero waits longest
    function automatic int stageDelay(input int idx);
        int half;
        half = idx / 2;
        return MAX_DELAY - half;
    endfunction

    // overlap sum of the aligned codes; each stage carries one redundant bit
    function automatic logic [RES_BITS-1:0] correctWord(
        input logic [NSTAGE-1:0][CODE_BITS-1:0] al
    );
        // accumulator one bit wider to catch over-range
        logic [RES_BITS:0] acc;
        acc = '0;
        for (int i = 0; i < NSTAGE; i++) begin
            acc = acc + ((RES_BITS + 1)'(al[i]) << (NSTAGE - 1 - i));
        end
        // an over-range sum clips to full scale rather than rolling over
        if (acc[RES_BITS]) begin
            return FULL_SCALE;
        end
        return acc[RES_BITS-1:0];
    endfunction

    // newest synchronised codes
    assign codes = st_q.codeSync[SYNC_STAGES-1];

    // edges taken from the last sync flop against one more flop
    assign convRise = st_q.convSync[SYNC_STAGES-1] && !st_q.convPrev;
    assign convFall = !st_q.convSync[SYNC_STAGES-1] && st_q.convPrev;

    // sleep level after synchronising
    assign sleeping = st_q.sleepSync[SYNC_STAGES-1];

    // pick each stage's aligned code from its own delay tap
    logic [NSTAGE-1:0][CODE_BITS-1:0] aligned;
    genvar g;
    generate
        for (g = 0; g < NSTAGE; g++) begin : g_align
            if (stageDelay(g) == 0) begin : g_direct
                // the last stage needs no delay
                assign aligned[g] = codes[g*CODE_BITS +: CODE_BITS];
            end else begin : g_tap
                // earlier stages wait in their own line
                assign aligned[g] = st_q.dly[g][stageDelay(g) - 1];
            end
        end
    endgenerate

    assign corrected = correctWord(aligned);

    // words are pushed one per convert cycle, dropped while invalid
    // a full buffer refuses the push and that word is lost
    assign pushValid = convRise && st_q.wordValid && !sleeping;

    // next state of every flop in the block
    always_comb begin
        st_d = st_q;

        // pin synchronisers shift every clock
        st_d.convSync = {st_q.convSync[SYNC_STAGES-2:0], convClk};
        st_d.convPrev = st_q.convSync[SYNC_STAGES-1];
        st_d.disSync = {st_q.disSync[SYNC_STAGES-2:0], outDisable_n};
        st_d.sleepSync = {st_q.sleepSync[SYNC_STAGES-2:0], sleepReq};
        st_d.codeSync = {st_q.codeSync[SYNC_STAGES-2:0], stageCode};

        // one idle cycle between phases keeps them from overlapping
        unique case (st_q.phase)
            PAB_GAP1: begin
                st_d.phase = PAB_PH1;
            end
            PAB_PH1: begin
                // sampling lasts while the convert clock is high
                st_d.phase = convFall ? PAB_GAP2 : PAB_PH1;
            end
            PAB_GAP2: begin
                st_d.phase = PAB_PH2;
            end
            PAB_PH2: begin
                // hold and redistribute while the convert clock is low
                st_d.phase = convRise ? PAB_GAP1 : PAB_PH2;
            end
            default: begin
                st_d.phase = PAB_GAP1;
            end
        endcase

        if (convRise) begin
            // all stages step together on the convert edge
            for (int i = 0; i < NSTAGE; i++) begin
                st_d.dly[i][0] = codes[i*CODE_BITS +: CODE_BITS];
                // shift each delay line by one
                for (int k = 1; k <= MAX_DELAY; k++) begin
                    st_d.dly[i][k] = st_q.dly[i][k-1];
                end
            end

            // word held one more cycle so the bus turns at cycle five
            st_d.word = corrected;
            // the word closing the invalid window is the first good one
            st_d.wordValid = (st_q.invalidCnt <= 3'h1) && !sleeping;
            // count down the words still to drop
            if (st_q.invalidCnt != '0 && !sleeping) begin
                st_d.invalidCnt = st_q.invalidCnt - 3'h1;
            end
        end
        // sleep scrambles the pipeline, so restart the invalid window
        if (sleeping) begin
            st_d.invalidCnt = INVALID_WORDS;
            st_d.wordValid = 1'b0;
        end
    end

    // phases park in hold and the invalid window is armed at reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.phase <= PAB_PH2;
            st_q.invalidCnt <= INVALID_WORDS;
        end else begin
            st_q <= st_d;
        end
    end

    // the buffer lets downstream stall without slowing the sample rate
    // output stream buffer; a full buffer drops the word and shows on bufferReady
    pab_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(pushValid),
        .inReady(bufferReady),
        .inData(st_q.word),
        .outValid(resultValid),
        .outReady(resultReady),
        .outData(resultData)
    );

    // bus drives only when neither disable nor sleep is high
    // the pin pull-down sits outside, so an open pin reads low here
    assign drive = !st_q.disSync[SYNC_STAGES-1] && !sleeping;

    // every data bit shares the one enable
    assign resultOe = {RES_BITS{drive}};

    // phases decoded straight from the one-hot state
    assign phase1 = (st_q.phase == PAB_PH1);
    assign phase2 = (st_q.phase == PAB_PH2);
endmodule

/* rtl/pab_pkg.sv */
// constants and types for the pipelined converter digital back end
package pab_pkg;
    localparam int NUM_STAGES = 9;
    localparam int CODE_BITS = 2;
    localparam int RES_BITS = 10;
    localparam int SYNC_STAGES = 2;
    // stages settle two per convert cycle, so the first one waits the longest
    localparam int MAX_DELAY = (NUM_STAGES - 1) / 2;
    localparam int LATENCY_CYCLES = 5;
    localparam logic [2:0] INVALID_WORDS = 3'h5;
    localparam int FIFO_DEPTH = 32;
    localparam logic [RES_BITS-1:0] FULL_SCALE = 10'h3ff;

    // one-hot phase generator states
    typedef enum logic [3:0] {
        PAB_GAP1 = 4'h1,
        PAB_PH1 = 4'h2,
        PAB_GAP2 = 4'h4,
        PAB_PH2 = 4'h8
    } pab_phase_e;

    typedef logic [CODE_BITS-1:0] pab_code_t;
endpackage

/* test/pab_backend_properties.sv */
// port checker for the converter back end
`timescale 1ns/1ps
module pab_backend_properties #(parameter int NSTAGE = 9, parameter int DEPTH = 32) (
    input wire logic clk, // clock
    input wire logic reset_n, // reset, low
    input wire logic convClk, // convert clock
    input wire logic [NSTAGE*2-1:0] stageCode, // codes
    input wire logic outDisable_n, // float request
    input wire logic sleepReq, // sleep
    input wire logic phase1, // sample phase
    input wire logic phase2, // hold phase
    input wire logic [9:0] resultData, // word
    input wire logic [9:0] resultOe, // enables
    input wire logic resultValid, // word valid
    input wire logic resultReady, // word taken
    input wire logic bufferReady // room
);
    // one clock domain throughout
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_excl; !(phase1 && phase2); endproperty
    a_excl: assert property (p_excl) else $error("phases overlap");
    property p_gap; $fell(phase1) |-> !phase2; endproperty
    a_gap: assert property (p_gap) else $error("no gap after sample phase");
    property p_rise; $rose(convClk) |-> ##[2:6] $fell(phase2); endproperty
    a_rise: assert property (p_rise) else $error("hold phase missed convert edge");
    property p_fall; $fell(convClk) |-> ##[2:6] $fell(phase1); endproperty
    a_fall: assert property (p_fall) else $error("sample phase missed fall");
    property p_float; outDisable_n [*3] |-> resultOe == 10'h0; endproperty
    a_float: assert property (p_float) else $error("bus driven while disabled");
    property p_drive; (!outDisable_n && !sleepReq) [*3] |-> resultOe == 10'h3ff; endproperty
    a_drive: assert property (p_drive) else $error("bus not driven");
    property p_sleep; sleepReq [*3] |-> resultOe == 10'h0; endproperty
    a_sleep: assert property (p_sleep) else $error("bus driven in sleep");
    property p_hold; resultValid && !resultReady |=> resultValid && $stable(resultData); endproperty
    a_hold: assert property (p_hold) else $error("head word lost");
endmodule
bind pab_backend pab_backend_properties #(.NSTAGE(NSTAGE), .DEPTH(DEPTH)) u_props (.clk(clk),
    .reset_n(reset_n), .convClk(convClk), .stageCode(stageCode), .outDisable_n(outDisable_n),
    .sleepReq(sleepReq), .phase1(phase1), .phase2(phase2), .resultData(resultData),
    .resultOe(resultOe), .resultValid(resultValid), .resultReady(resultReady), .bufferReady(bufferReady));

/* test/pab_backend_tb.sv */
// self-checking bench for the converter back end
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module pab_backend_tb;
    logic clk = 0, reset_n = 1, convClk = 0, outDisable_n = 0, sleepReq = 0, holdOff = 0, slow = 0;
    logic [17:0] stageCode = 18'h0;
    logic [9:0] resultData, resultOe, lastWord;
    logic phase1, phase2, resultValid, resultReady, bufferReady;
    int num_errors = 0, compares = 0, wordCount, c, seed = 32'h3c8d2039;
    always #50 clk = ~clk;
    pab_backend dut (.clk(clk), .reset_n(reset_n), .convClk(convClk), .stageCode(stageCode),
        .outDisable_n(outDisable_n), .sleepReq(sleepReq), .phase1(phase1), .phase2(phase2),
        .resultData(resultData), .resultOe(resultOe), .resultValid(resultValid),
        .resultReady(resultReady), .bufferReady(bufferReady));
    pab_sink sink (.clk(clk), .reset_n(reset_n), .resultValid(resultValid), .resultData(resultData),
        .holdOff(holdOff), .slow(slow), .resultReady(resultReady), .lastWord(lastWord), .wordCount(wordCount));
    // weighted sum of stage codes, clipped at full scale
    function automatic logic [9:0] exp_word(logic [17:0] s);
        int t = 0;
        for (int i = 0; i < 9; i++) t += int'(s[2*i+:2]) << (8 - i);
        return t > 1023 ? 10'h3ff : t[9:0];
    endfunction
    // convert clock held 4 clocks each level, slow against clk
    task conv(int n);
        repeat (n) begin
            convClk <= 1'b1;
            repeat (4) @(posedge clk);
            convClk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // run is well under 5 ms
    initial begin
        #5000000;
        num_errors++;
        conclude;
    end
    initial begin
        // a real falling edge so the asynchronous reset takes hold
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        conv(6);
        for (int k = 0; k < 7; k++) begin
            stageCode <= k == 0 ? 18'h0 : k == 1 ? 18'h3ffff : k == 2 ? 18'h2 : 18'($random(seed));
            slow <= k[0];
            conv(8);
            repeat (8) @(posedge clk);
            `CHK(lastWord, exp_word(stageCode))
        end
        $display("codes test done");
        stageCode <= 18'h0;
        conv(8);
        stageCode <= 18'h3ffff;
        conv(5);
        `CHK(lastWord == 10'h3ff, 1'b0)
        conv(1);
        repeat (8) @(posedge clk);
        `CHK(lastWord, 10'h3ff)
        $display("latency test done");
        sleepReq <= 1'b1;
        conv(2);
        `CHK(resultOe, 10'h0)
        c = wordCount;
        sleepReq <= 1'b0;
        conv(5);
        `CHK(wordCount, c)
        conv(2);
        `CHK(wordCount > c, 1'b1)
        `CHK(lastWord, 10'h3ff)
        $display("sleep test done");
        // disable only toggled while the convert clock is idle
        outDisable_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(resultOe, 10'h0)
        outDisable_n <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(resultOe, 10'h3ff)
        $display("disable test done");
        c = wordCount;
        holdOff <= 1'b1;
        conv(40);
        `CHK(bufferReady, 1'b0)
        holdOff <= 1'b0;
        repeat (40) @(posedge clk);
        `CHK(resultValid, 1'b0)
        `CHK(wordCount - c, 32)
        $display("buffer test done");
        conclude;
    end
endmodule

/* test/pab_sink.sv */
// downstream capture logic model
`timescale 1ns/1ps
module pab_sink (
    input wire logic clk, // clock
    input wire logic reset_n, // reset, low
    input wire logic resultValid, // word valid
    input wire logic [9:0] resultData, // word
    input wire logic holdOff, // stall fully
    input wire logic slow, // stall one in four
    output logic resultReady, // take word
    output logic [9:0] lastWord, // last captured
    output int wordCount // words captured
);
    logic [1:0] cnt;
    // slow mode stalls periodically so head words must wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 2'h0;
            resultReady <= 1'b0;
            lastWord <= 10'h0;
            wordCount <= 0;
        end else begin
            cnt <= cnt + 2'h1;
            resultReady <= !holdOff && !(slow && cnt == 2'h0);
            if (resultValid && resultReady) begin
                lastWord <= resultData;
                wordCount <= wordCount + 1;
            end
        end
    end
endmodule
